// ===== common/ufc_pkg.sv
// Constants, types and helpers shared by the FIFO trigger and hardware flow control block
`default_nettype none
package ufc_pkg;

	localparam int FIFO_DEPTH = 64;
	localparam int LEVEL_W = 7;

	// Field positions inside the control registers
	localparam int FCR_ENABLE_BIT = 0;
	localparam int FCR_TX_SEL_LO = 4;
	localparam int FCR_RX_SEL_LO = 6;
	localparam int FEATURE_CONTROL_REG_TABLE_LO = 4;
	localparam int FEATURE_CONTROL_REG_HYST_LO = 0;
	localparam int EFR_ENH_BIT = 4;
	localparam int EFR_AUTO_RTS_BIT = 6;
	localparam int EFR_AUTO_CTS_BIT = 7;
	localparam int THR_HALT_LO = 0;
	localparam int THR_RESUME_LO = 4;
	localparam int DTL_RX_LO = 0;
	localparam int DTL_TX_LO = 4;
	// Threshold and direct trigger nibbles count in steps of four characters
	localparam int NIBBLE_SHIFT = 2;

	localparam logic [1:0] TABLE_A = 2'h0;
	localparam logic [1:0] TABLE_B = 2'h1;
	localparam logic [1:0] TABLE_C = 2'h2;
	localparam logic [1:0] TABLE_D = 2'h3;

	localparam logic [LEVEL_W-1:0] LEVEL_ONE = 7'h01;
	localparam logic [LEVEL_W-1:0] LEVEL_ZERO = 7'h00;

	// Register reset values
	localparam logic [7:0] FCR_RESET = 8'h00;
	localparam logic [7:0] FEATURE_CONTROL_REG_RESET = 8'h20;
	localparam logic [7:0] EFR_RESET = 8'h00;

	typedef struct packed {
		logic [7:0] fifoCtrl;       // fifo_control_reg
		logic [7:0] featureCtrl;    // feature_control_reg
		logic [7:0] enhFeature;     // enhanced_feature_reg
		logic [7:0] flowThreshold;  // flow_threshold_reg
		logic [7:0] directTrigger;  // direct_trigger_level_reg
		logic [LEVEL_W-1:0] rxTrigValue; // receive_trigger_value
		logic [LEVEL_W-1:0] txTrigValue; // transmit_trigger_value
		logic modemRts;             // modem_control_reg bit 1
		logic ierRts;               // interrupt_enable_reg bit 6
		logic ierCts;               // interrupt_enable_reg bit 7
	} ufc_ctrl_type;

	typedef struct packed {
		logic [LEVEL_W-1:0] rxLevel;
		logic [LEVEL_W-1:0] txLevel;
	} ufc_levels_type;

	// Hysteresis characters by feature-control code
	function automatic logic [LEVEL_W-1:0] hystChars(input logic [3:0] code);
		case (code)
			4'h0: hystChars = 7'h00;
			4'h1: hystChars = 7'h04;
			4'h2: hystChars = 7'h06;
			4'h3: hystChars = 7'h08;
			4'h4: hystChars = 7'h08;
			4'h5: hystChars = 7'h10;
			4'h6: hystChars = 7'h18;
			4'h7: hystChars = 7'h20;
			4'h8: hystChars = 7'h28;
			4'h9: hystChars = 7'h2c;
			4'ha: hystChars = 7'h30;
			4'hb: hystChars = 7'h34;
			4'hc: hystChars = 7'h0c;
			4'hd: hystChars = 7'h14;
			4'he: hystChars = 7'h1c;
			default: hystChars = 7'h24;
		endcase
	endfunction : hystChars

endpackage : ufc_pkg
`default_nettype wire

// ===== src/ufc_flow_trigger.sv
// Trigger level selection and automatic RTS/CTS flow control for one channel
`timescale 1ns/1ps
`default_nettype none
module ufc_flow_trigger #(
	parameter int DEPTH = ufc_pkg::FIFO_DEPTH
) (
	input wire logic clk, // 200 MHz clock
	input wire logic rst_n, // Synchronous reset, active low
	input wire ufc_pkg::ufc_ctrl_type ctrl, // Software control bits
	input wire ufc_pkg::ufc_levels_type levels, // Live FIFO fill counters
	input wire logic txBusy, // Transmit shift register holds a character
	input wire logic txStopDone, // Pulse: stop bit of current character sent
	input wire logic statusClear, // Pulse: clear the flow transition status bit
	input wire logic cts_n, // Clear-to-send pin, active low, asynchronous
	output logic rts_n, // Request-to-send pin, active low
	output logic txEnable, // Transmitter may start a new character
	output logic rxTrigger, // Receive trigger reached, DMA and interrupt
	output logic txTrigger, // Transmit trigger reached, DMA and interrupt
	output logic rxRoom, // Receive FIFO not full, receiver may store
	output logic flowStatus, // Sticky RTS/CTS transition status bit
	output logic [ufc_pkg::LEVEL_W-1:0] rxLevelSel, // Selected receive trigger level
	output logic [ufc_pkg::LEVEL_W-1:0] txLevelSel // Selected transmit trigger level
);
	localparam logic [ufc_pkg::LEVEL_W-1:0] DEPTH_L = ufc_pkg::LEVEL_W'(DEPTH);

	// Receive table entry; index 4 is the top of the FIFO, index 7 is empty
	function automatic logic [ufc_pkg::LEVEL_W-1:0] rxTable(input logic [1:0] tbl,
			input logic [2:0] idx);
		logic [ufc_pkg::LEVEL_W-1:0] lv;
		lv = ufc_pkg::LEVEL_ZERO;
		if (idx == 3'h4) begin
			lv = DEPTH_L;
		end else if (idx == 3'h7) begin
			lv = ufc_pkg::LEVEL_ZERO;
		end else if (tbl == ufc_pkg::TABLE_A) begin
			case (idx[1:0])
				2'h0: lv = 7'h01;
				2'h1: lv = 7'h04;
				2'h2: lv = 7'h08;
				default: lv = 7'h0e;
			endcase
		end else if (tbl == ufc_pkg::TABLE_B) begin
			case (idx[1:0])
				2'h0: lv = 7'h08;
				2'h1: lv = 7'h10;
				2'h2: lv = 7'h18;
				default: lv = 7'h1c;
			endcase
		end else begin
			case (idx[1:0])
				2'h0: lv = 7'h08;
				2'h1: lv = 7'h10;
				2'h2: lv = 7'h38;
				default: lv = 7'h3c;
			endcase
		end
		return lv;
	endfunction : rxTable

	function automatic logic [ufc_pkg::LEVEL_W-1:0] txTable(input logic [1:0] tbl,
			input logic [1:0] idx);
		logic [ufc_pkg::LEVEL_W-1:0] lv;
		lv = ufc_pkg::LEVEL_ONE;
		if (tbl == ufc_pkg::TABLE_B) begin
			case (idx)
				2'h0: lv = 7'h10;
				2'h1: lv = 7'h08;
				2'h2: lv = 7'h18;
				default: lv = 7'h1e;
			endcase
		end else if (tbl == ufc_pkg::TABLE_C) begin
			case (idx)
				2'h0: lv = 7'h08;
				2'h1: lv = 7'h10;
				2'h2: lv = 7'h20;
				default: lv = 7'h38;
			endcase
		end
		return lv;
	endfunction : txTable

	// Saturating arithmetic on fill levels
	function automatic logic [ufc_pkg::LEVEL_W-1:0] satAdd(input logic [ufc_pkg::LEVEL_W-1:0] a,
			input logic [ufc_pkg::LEVEL_W-1:0] b);
		logic [ufc_pkg::LEVEL_W:0] s;
		s = {1'b0, a} + {1'b0, b};
		return (s > {1'b0, DEPTH_L}) ? DEPTH_L : s[ufc_pkg::LEVEL_W-1:0];
	endfunction : satAdd

	function automatic logic [ufc_pkg::LEVEL_W-1:0] satSub(input logic [ufc_pkg::LEVEL_W-1:0] a,
			input logic [ufc_pkg::LEVEL_W-1:0] b);
		return (a > b) ? a - b : ufc_pkg::LEVEL_ZERO;
	endfunction : satSub

	// Level selection
	logic [1:0] tableSel, rxIdx, txIdx;
	logic [3:0] dtlRx, dtlTx, halfHalt, halfResume;
	logic fifoOn, autoRts, autoCts, enhOn;
	logic [ufc_pkg::LEVEL_W-1:0] rxLv, txLv, haltLv, resumeLv, hyst, tblD;

	assign tableSel = ctrl.featureCtrl[ufc_pkg::FEATURE_CONTROL_REG_TABLE_LO +: 2];
	assign rxIdx = ctrl.fifoCtrl[ufc_pkg::FCR_RX_SEL_LO +: 2];
	assign txIdx = ctrl.fifoCtrl[ufc_pkg::FCR_TX_SEL_LO +: 2];
	assign dtlRx = ctrl.directTrigger[ufc_pkg::DTL_RX_LO +: 4];
	assign dtlTx = ctrl.directTrigger[ufc_pkg::DTL_TX_LO +: 4];
	assign halfHalt = ctrl.flowThreshold[ufc_pkg::THR_HALT_LO +: 4];
	assign halfResume = ctrl.flowThreshold[ufc_pkg::THR_RESUME_LO +: 4];
	assign fifoOn = ctrl.fifoCtrl[ufc_pkg::FCR_ENABLE_BIT];
	assign autoRts = ctrl.enhFeature[ufc_pkg::EFR_AUTO_RTS_BIT];
	assign autoCts = ctrl.enhFeature[ufc_pkg::EFR_AUTO_CTS_BIT];
	assign enhOn = ctrl.enhFeature[ufc_pkg::EFR_ENH_BIT];
	assign hyst = ufc_pkg::hystChars(ctrl.featureCtrl[ufc_pkg::FEATURE_CONTROL_REG_HYST_LO +: 4]);
	assign tblD = (ctrl.rxTrigValue == ufc_pkg::LEVEL_ZERO) ? ufc_pkg::LEVEL_ONE
		: ctrl.rxTrigValue;

	always_comb begin
		rxLv = ufc_pkg::LEVEL_ONE;
		txLv = ufc_pkg::LEVEL_ONE;
		haltLv = ufc_pkg::LEVEL_ONE;
		resumeLv = ufc_pkg::LEVEL_ZERO;
		if (!fifoOn) begin
			rxLv = ufc_pkg::LEVEL_ONE;
			txLv = ufc_pkg::LEVEL_ONE;
		end else if (ctrl.directTrigger != 8'h00) begin
			// A zero nibble keeps that direction at one character
			rxLv = (dtlRx == 4'h0) ? ufc_pkg::LEVEL_ONE
				: ufc_pkg::LEVEL_W'({dtlRx, 2'b00});
			txLv = (dtlTx == 4'h0) ? ufc_pkg::LEVEL_ONE
				: ufc_pkg::LEVEL_W'({dtlTx, 2'b00});
			haltLv = rxLv;
			resumeLv = satSub(rxLv, ufc_pkg::LEVEL_ONE);
		end else if (tableSel == ufc_pkg::TABLE_D) begin
			rxLv = tblD;
			txLv = (ctrl.txTrigValue == ufc_pkg::LEVEL_ZERO) ? ufc_pkg::LEVEL_ONE
				: ctrl.txTrigValue;
			haltLv = satAdd(tblD, hyst);
			resumeLv = satSub(tblD, hyst);
		end else begin
			rxLv = rxTable(tableSel, {1'b0, rxIdx});
			txLv = (tableSel == ufc_pkg::TABLE_A) ? ufc_pkg::LEVEL_ONE
				: txTable(tableSel, txIdx);
			haltLv = rxTable(tableSel, 3'({1'b0, rxIdx} + 3'h1));
			resumeLv = rxTable(tableSel, 3'({1'b0, rxIdx} - 3'h1));
		end
		if (fifoOn && halfHalt != 4'h0) begin
			haltLv = ufc_pkg::LEVEL_W'({halfHalt, 2'b00});
		end
		if (fifoOn && halfResume != 4'h0) begin
			resumeLv = ufc_pkg::LEVEL_W'({halfResume, 2'b00});
		end
	end

	// Registered flow state
	logic ctsMeta_q, ctsSync_q, ctsPrev_q;
	logic haltHeld_q, haltHeld_d;
	logic rtsN_q, rtsN_d, txEn_q, txEn_d, stat_q, stat_d;
	logic rxTrig_q, rxTrig_d, txTrig_q, txTrig_d, rxRoom_q, rxRoom_d;
	logic [ufc_pkg::LEVEL_W-1:0] rxSel_q, txSel_q;
	logic rtsEvent, ctsEvent;

	always_comb begin
		haltHeld_d = haltHeld_q;
		if (!(autoRts && ctrl.modemRts)) begin
			haltHeld_d = 1'b0;
		end else if (levels.rxLevel >= haltLv) begin
			haltHeld_d = 1'b1;
		end else if (levels.rxLevel <= resumeLv) begin
			haltHeld_d = 1'b0;
		end
		// Without modem-control bit 1 the pin stays high even in auto mode
		rtsN_d = !ctrl.modemRts || haltHeld_d;
		// With auto-CTS on, gate changes only between characters so a frame is never cut
		txEn_d = txEn_q;
		if (!autoCts) begin
			txEn_d = 1'b1;
		end else if (!txBusy || txStopDone) begin
			txEn_d = !ctsSync_q;
		end
		rtsEvent = enhOn && ctrl.ierRts && (rtsN_d != rtsN_q);
		ctsEvent = enhOn && ctrl.ierCts && (ctsSync_q != ctsPrev_q);
		// A new transition wins over a clear in the same cycle
		stat_d = rtsEvent || ctsEvent || (stat_q && !statusClear);
		rxTrig_d = levels.rxLevel >= rxLv;
		txTrig_d = satSub(DEPTH_L, levels.txLevel) >= txLv;
		rxRoom_d = levels.rxLevel < DEPTH_L;
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ctsMeta_q <= 1'b1;
			ctsSync_q <= 1'b1;
			ctsPrev_q <= 1'b1;
			haltHeld_q <= 1'b0;
			rtsN_q <= 1'b1;
			txEn_q <= 1'b1;
			stat_q <= 1'b0;
			rxTrig_q <= 1'b0;
			txTrig_q <= 1'b0;
			rxRoom_q <= 1'b1;
			rxSel_q <= ufc_pkg::LEVEL_ONE;
			txSel_q <= ufc_pkg::LEVEL_ONE;
		end else begin
			ctsMeta_q <= cts_n;
			ctsSync_q <= ctsMeta_q;
			ctsPrev_q <= ctsSync_q;
			haltHeld_q <= haltHeld_d;
			rtsN_q <= rtsN_d;
			txEn_q <= txEn_d;
			stat_q <= stat_d;
			rxTrig_q <= rxTrig_d;
			txTrig_q <= txTrig_d;
			rxRoom_q <= rxRoom_d;
			rxSel_q <= rxLv;
			txSel_q <= txLv;
		end
	end

	assign rts_n = rtsN_q;
	assign txEnable = txEn_q;
	assign rxTrigger = rxTrig_q;
	assign txTrigger = txTrig_q;
	assign rxRoom = rxRoom_q;
	assign flowStatus = stat_q;
	assign rxLevelSel = rxSel_q;
	assign txLevelSel = txSel_q;

endmodule : ufc_flow_trigger
`default_nettype wire

// ===== dv/ufc_flow_trigger_monitor.sv
// Port checks for the flow trigger block
`timescale 1ns/1ps
`default_nettype none
module ufc_flow_trigger_monitor #(
	parameter int DEPTH = 64
) (
	input wire logic clk, // Clock
	input wire logic rst_n, // Reset
	input wire ufc_pkg::ufc_ctrl_type ctrl, // Controls
	input wire ufc_pkg::ufc_levels_type levels, // Fill
	input wire logic txBusy, // Busy
	input wire logic txStopDone, // Stop
	input wire logic statusClear, // Clear
	input wire logic cts_n, // CTS
	input wire logic rts_n, // RTS
	input wire logic txEnable, // Tx ok
	input wire logic rxTrigger, // Rx trig
	input wire logic txTrigger, // Tx trig
	input wire logic rxRoom, // Room
	input wire logic flowStatus, // Status
	input wire logic [ufc_pkg::LEVEL_W-1:0] rxLevelSel, // Rx sel
	input wire logic [ufc_pkg::LEVEL_W-1:0] txLevelSel // Tx sel
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	sequence ctsIdle;
		!cts_n && !txBusy && ctrl.enhFeature[7];
	endsequence
	sequence ctsStop;
		(cts_n && ctrl.enhFeature[7]) [*4] ##0 txStopDone;
	endsequence
	// Four cycles cover the two-flop synchroniser plus the output register
	AST_CTS_GO: assert property (ctsIdle [*4] |=> txEnable)
		else $error("transmit not resumed");
	AST_CTS_STOP: assert property (ctsStop |=> !txEnable)
		else $error("transmit not stopped");
	AST_CTS_HOLD: assert property ($past(rst_n) && ctrl.enhFeature[7] && txBusy && !txStopDone
		|=> $stable(txEnable)) else $error("stop mid character");
	AST_ROOM: assert property ($past(rst_n) |-> rxRoom == ($past(levels.rxLevel) < DEPTH))
		else $error("room flag wrong");
	AST_RECEIVE_TRIGGER_VALUE: assert property ($past(rst_n) && $stable(rxLevelSel)
		|-> rxTrigger == ($past(levels.rxLevel) >= rxLevelSel))
		else $error("rx trigger wrong");
	AST_TRANSMIT_TRIGGER_VALUE: assert property ($past(rst_n) && $stable(txLevelSel)
		|-> txTrigger == ((DEPTH - $past(levels.txLevel)) >= txLevelSel))
		else $error("tx trigger wrong");
	AST_SOFT_RTS: assert property ($past(rst_n) && !$past(ctrl.enhFeature[6])
		|-> rts_n == !$past(ctrl.modemRts)) else $error("manual rts wrong");
	AST_RTS_START: assert property ($past(rst_n) && ctrl.enhFeature[6] && !ctrl.modemRts
		|=> rts_n) else $error("rts without start");
	AST_HALT_FULL: assert property ($past(rst_n) && ctrl.enhFeature[6] && levels.rxLevel == DEPTH
		|=> rts_n) else $error("rts low when full");
	AST_RESUME_EMPTY: assert property ($past(rst_n) && ctrl.enhFeature[6] && ctrl.modemRts
		&& levels.rxLevel == 0 |=> !rts_n) else $error("rts high when empty");
	AST_NO_ENH: assert property ($past(rst_n) && !ctrl.enhFeature[4] && !flowStatus
		|=> !flowStatus) else $error("status without enable");
endmodule : ufc_flow_trigger_monitor
bind ufc_flow_trigger ufc_flow_trigger_monitor #(.DEPTH(DEPTH)) uMon (.clk(clk), .rst_n(rst_n),
	.ctrl(ctrl), .levels(levels), .txBusy(txBusy), .txStopDone(txStopDone),
	.statusClear(statusClear), .cts_n(cts_n), .rts_n(rts_n), .txEnable(txEnable),
	.rxTrigger(rxTrigger), .txTrigger(txTrigger), .rxRoom(rxRoom), .flowStatus(flowStatus),
	.rxLevelSel(rxLevelSel), .txLevelSel(txLevelSel));
`default_nettype wire

// ===== dv/ufc_remote_peer.sv
// Behavioural remote UART on the far side of the serial line
`timescale 1ns/1ps
`default_nettype none
module ufc_remote_peer (
	input wire logic clk, // Clock
	input wire logic rst_n, // Reset
	input wire logic rts_n, // Our RTS
	input wire logic sendOn, // Remote has data
	input wire logic drain, // Host reads one
	input wire logic ctsHold, // Remote wants pause
	output logic [6:0] rxCount, // Our rx fill
	output logic cts_n // CTS to us
);
	logic [1:0] tickQ;
	// One character every four cycles keeps fills easy to predict
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rxCount <= 7'h00;
			tickQ <= 2'h0;
			cts_n <= 1'b1;
		end else begin
			tickQ <= tickQ + 2'h1;
			cts_n <= ctsHold;
			if (drain && rxCount != 7'h00)
				rxCount <= rxCount - 7'h01;
			else if (sendOn && !rts_n && tickQ == 2'h3 && rxCount < 7'h40)
				rxCount <= rxCount + 7'h01;
		end
	end
endmodule : ufc_remote_peer
`default_nettype wire

// ===== dv/ufc_flow_trigger_tb.sv
// Self-checking bench for the flow trigger block
`timescale 1ns/1ps
`default_nettype none
module ufc_flow_trigger_tb;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	ufc_pkg::ufc_ctrl_type ctrl = '0;
	ufc_pkg::ufc_levels_type levels;
	logic [6:0] rxCount;
	logic [6:0] txLvl = 7'h00;
	logic txBusy = 1'b0;
	logic txStopDone = 1'b0;
	logic statusClear = 1'b0;
	logic sendOn = 1'b0;
	logic drain = 1'b0;
	logic ctsHold = 1'b0;
	logic cts_n, rts_n, txEnable, rxTrigger, txTrigger, rxRoom, flowStatus;
	logic [6:0] rxLevelSel, txLevelSel;
	int errCount = 0;
	int numChecks = 0;
	assign levels = '{rxLevel: rxCount, txLevel: txLvl};
	always #2.5 clk = ~clk;
	ufc_flow_trigger DUT (.clk(clk), .rst_n(rst_n), .ctrl(ctrl), .levels(levels),
		.txBusy(txBusy), .txStopDone(txStopDone), .statusClear(statusClear), .cts_n(cts_n),
		.rts_n(rts_n), .txEnable(txEnable), .rxTrigger(rxTrigger), .txTrigger(txTrigger),
		.rxRoom(rxRoom), .flowStatus(flowStatus), .rxLevelSel(rxLevelSel),
		.txLevelSel(txLevelSel));
	ufc_remote_peer uPeer (.clk(clk), .rst_n(rst_n), .rts_n(rts_n), .sendOn(sendOn),
		.drain(drain), .ctsHold(ctsHold), .rxCount(rxCount), .cts_n(cts_n));
	task automatic chk(input string nm, input logic [6:0] seen, input logic [6:0] exp);
		numChecks++;
		if (seen !== exp) begin
			errCount++;
			$display("MISMATCH %s exp %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic settle(input int n);
		repeat (n) @(posedge clk);
		@(negedge clk);
	endtask : settle
	task automatic testReset;
		@(posedge clk);
		ctrl.fifoCtrl <= 8'hf0;
		ctrl.featureCtrl <= 8'h10;
		settle(1);
		chk("rxSel", rxLevelSel, 7'h01);
		chk("txSel", txLevelSel, 7'h01);
		chk("rts", 7'(rts_n), 7'h01);
	endtask : testReset
	task automatic testTables;
		logic [6:0] rxTab [12] = '{1, 4, 8, 14, 8, 16, 24, 28, 8, 16, 56, 60};
		logic [6:0] txTab [12] = '{1, 1, 1, 1, 30, 24, 8, 16, 56, 32, 16, 8};
		for (int i = 0; i < 12; i++) begin
			@(posedge clk);
			ctrl.featureCtrl <= {2'h0, 2'(i / 4), 4'h0};
			// Receive and transmit selects run opposite ways to show independence
			ctrl.fifoCtrl <= {2'(i % 4), 2'(3 - i % 4), 4'h1};
			settle(1);
			chk("rxSel", rxLevelSel, rxTab[i]);
			chk("txSel", txLevelSel, txTab[i]);
		end
		@(posedge clk);
		ctrl.featureCtrl <= 8'h30;
		ctrl.rxTrigValue <= 7'h21;
		ctrl.txTrigValue <= 7'h05;
		txLvl <= 7'h3b;
		settle(1);
		chk("rxD", rxLevelSel, 7'h21);
		chk("txD", txLevelSel, 7'h05);
		chk("txTrg", 7'(txTrigger), 7'h01);
		@(posedge clk);
		txLvl <= 7'h3c;
		settle(1);
		chk("txTrg", 7'(txTrigger), 7'h00);
		@(posedge clk);
		ctrl.directTrigger <= 8'h32;
		settle(1);
		chk("rxDir", rxLevelSel, 7'h08);
		chk("txDir", txLevelSel, 7'h0c);
	endtask : testTables
	task automatic testRts;
		@(posedge clk);
		ctrl.directTrigger <= 8'h00;
		ctrl.featureCtrl <= 8'h00;
		ctrl.fifoCtrl <= 8'h41;
		ctrl.enhFeature <= 8'h50;
		ctrl.ierRts <= 1'b1;
		@(posedge clk);
		ctrl.modemRts <= 1'b1;
		settle(2);
		chk("rtsGo", 7'(rts_n), 7'h00);
		@(posedge clk);
		statusClear <= 1'b1;
		sendOn <= 1'b1;
		@(posedge clk);
		statusClear <= 1'b0;
		for (int k = 0; k < 100 && rts_n !== 1'b1; k++)
			settle(0);
		settle(8);
		chk("halt", rxCount, 7'h08);
		chk("rxTrg", 7'(rxTrigger), 7'h01);
		chk("room", 7'(rxRoom), 7'h01);
		chk("stat", 7'(flowStatus), 7'h01);
		@(posedge clk);
		sendOn <= 1'b0;
		statusClear <= 1'b1;
		@(posedge clk);
		statusClear <= 1'b0;
		for (int k = 0; k < 7; k++) begin
			@(posedge clk);
			drain <= 1'b1;
			@(posedge clk);
			drain <= 1'b0;
			settle(1);
			chk("resume", 7'(rts_n), (k < 6) ? 7'h01 : 7'h00);
		end
		chk("stat", 7'(flowStatus), 7'h01);
	endtask : testRts
	task automatic testCts;
		@(posedge clk);
		ctrl.enhFeature <= 8'h90;
		ctrl.ierCts <= 1'b1;
		ctrl.ierRts <= 1'b0;
		txBusy <= 1'b1;
		ctsHold <= 1'b1;
		settle(6);
		chk("rtsMan", 7'(rts_n), 7'h00);
		chk("txHold", 7'(txEnable), 7'h01);
		@(posedge clk);
		statusClear <= 1'b1;
		txStopDone <= 1'b1;
		@(posedge clk);
		statusClear <= 1'b0;
		txStopDone <= 1'b0;
		settle(1);
		chk("txStop", 7'(txEnable), 7'h00);
		chk("stat", 7'(flowStatus), 7'h00);
		@(posedge clk);
		txBusy <= 1'b0;
		ctsHold <= 1'b0;
		settle(5);
		chk("txGo", 7'(txEnable), 7'h01);
		chk("stat", 7'(flowStatus), 7'h01);
	endtask : testCts
	task automatic testFull;
		// Auto-RTS off keeps RTS low, so the remote fills the receive FIFO to the top
		@(posedge clk);
		sendOn <= 1'b1;
		for (int k = 0; k < 400 && rxCount !== 7'h40; k++)
			settle(0);
		settle(1);
		chk("full", rxCount, 7'h40);
		chk("roomFull", 7'(rxRoom), 7'h00);
		@(posedge clk);
		sendOn <= 1'b0;
		ctrl.enhFeature <= 8'hd0;
		settle(1);
		chk("haltFull", 7'(rts_n), 7'h01);
	endtask : testFull
	task automatic wrapUp;
		$display("checks %0d errors %0d", numChecks, errCount);
		if (errCount == 0 && numChecks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : wrapUp
	initial begin
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		testReset;
		testTables;
		testRts;
		testCts;
		testFull;
		wrapUp;
	end
	initial begin
		repeat (3000) @(posedge clk);
		errCount++;
		wrapUp;
	end
endmodule : ufc_flow_trigger_tb
`default_nettype wire
